//--- logic/output_driver_gain_control.sv
// Purpose: Driver gain, mute, config registers with settle flags and debounce
// Assumes: All inputs except rstn synchronous to core_clk; page selection done outside
// Notes: Applied gain ramps one code per step toward the programmed code
`timescale 1ns/1ns
`default_nettype none

module output_driver_gain_control
(
    input  wire logic                                    core_clk,     // 100 MHz clock
    input  wire logic                                    rstn,         // Async reset, low
    input  wire output_driver_gain_control_pkg::regReq_s regReq,       // Register request
    output var  logic [7:0]                              regRdData,    // Read data
    output var  logic                                    regRdValid,   // Read data strobe
    input  wire logic                                    timerUseMclk, // 1: master clock source
    input  wire logic [6:0]                              timerDivisor, // Master clock divisor
    input  wire logic                                    mclkTick,     // Master clock edge pulse
    input  wire logic                                    oscTick,      // Oscillator edge pulse
    input  wire logic                                    shortDetIn,   // Raw short-circuit level
    output var  logic                                    shortDetOut,  // Debounced short level
    output var  logic [3:0]                              leftHpGain,   // Left gain code
    output var  logic                                    leftHpUnmute, // Left unmuted
    output var  logic [3:0]                              rightHpGain,  // Right gain code
    output var  logic                                    rightHpUnmute,// Right unmuted
    output var  logic [1:0]                              speakerGain,  // Speaker gain code
    output var  logic                                    speakerUnmute,// Speaker unmuted
    output var  logic                                    leftLineout,  // Left as lineout
    output var  logic                                    rightLineout, // Right as lineout
    output var  logic [1:0]                              dacPerfMode   // DAC performance mode
);
    import output_driver_gain_control_pkg::*;

    logic       rstSync1_r;
    logic       rstSync2_r;
    logic       rstLocal;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end
        else
        begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    assign rstLocal = rstSync2_r;

    // Target gain and mute of a driver as {gain4, unmute}
    function automatic logic [4:0] targetOf(input int idx, input logic [6:0] ctrl);
        logic [4:0] t;
        t = 5'h00;
        if (idx == 2)
            t = {2'b00, ctrl[SPK_GAIN_LSB+1-1 -: 2], ctrl[MUTE_BIT-1]};
        else
            t = {ctrl[HP_GAIN_LSB+3-1 -: 4], ctrl[MUTE_BIT-1]};
        return t;
    endfunction

    logic [6:0] drvCtrl_r   [3];
    logic [6:0] drvCtrl_nxt [3];
    logic [4:0] applied_r   [3];
    logic [4:0] applied_nxt [3];
    logic [2:0] settled;
    logic [7:0] hpConfig_r;
    logic [7:0] hpConfig_nxt;
    logic [7:0] rdData_r;
    logic [7:0] rdData_nxt;
    logic       rdValid_r;
    logic [6:0] stepCnt_r;
    logic [6:0] stepCnt_nxt;
    logic       stepTick;

    always_comb
    begin
        stepTick    = (stepCnt_r == 7'(GAIN_STEP_CYC - 1));
        stepCnt_nxt = stepTick ? 7'h00 : stepCnt_r + 7'h01;
    end

    // Stored bit k of ctrl is register bit k+1; bit 0 is the settle flag
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gDrv
            logic [6:0] addrOfs;
            logic [4:0] tgt;
            assign addrOfs = (g == 0) ? LEFT_HP_OFS : (g == 1) ? RIGHT_HP_OFS : SPEAKER_OFS;
            assign tgt     = targetOf(g, drvCtrl_r[g]);
            // RL6 RL7 RL10 settle compare
            assign settled[g] = (applied_r[g] == tgt);

            always_comb
            begin
                drvCtrl_nxt[g] = drvCtrl_r[g];
                // RL1 RL3 RL8 field store
                if (regReq.wr && regReq.addr == addrOfs)
                    drvCtrl_nxt[g] = regReq.data[7:1];
                applied_nxt[g] = applied_r[g];
                // RL20 ramp toward target
                if (stepTick)
                begin
                    applied_nxt[g][0] = tgt[0];
                    if (applied_r[g][4:1] < tgt[4:1])
                        applied_nxt[g][4:1] = applied_r[g][4:1] + 4'h1;
                    else if (applied_r[g][4:1] > tgt[4:1])
                        applied_nxt[g][4:1] = applied_r[g][4:1] - 4'h1;
                end
            end

            always_ff @(posedge core_clk or negedge rstLocal)
            begin
                if (!rstLocal)
                begin
                    // RL4 RL5 RL9 muted at reset
                    drvCtrl_r[g] <= (g == 0) ? LEFT_HP_RST : (g == 1) ? RIGHT_HP_RST : SPEAKER_RST;
                    applied_r[g] <= 5'h00;
                end
                else
                begin
                    drvCtrl_r[g] <= drvCtrl_nxt[g];
                    applied_r[g] <= applied_nxt[g];
                end
            end
        end
    endgenerate

    always_comb
    begin
        hpConfig_nxt = hpConfig_r;
        // RL14 RL18 config store
        if (regReq.wr && regReq.addr == HP_CONFIG_OFS)
            hpConfig_nxt = regReq.data;
        rdData_nxt = 8'h00;
        if (regReq.rd)
        begin
            unique case (regReq.addr)
                LEFT_HP_OFS:   rdData_nxt = {drvCtrl_r[0], settled[0]};
                RIGHT_HP_OFS:  rdData_nxt = {drvCtrl_r[1], settled[1]};
                SPEAKER_OFS:   rdData_nxt = {drvCtrl_r[2], settled[2]};
                // RL17 reserved reads zero
                RESERVED_OFS:  rdData_nxt = RESERVED_VAL;
                HP_CONFIG_OFS: rdData_nxt = hpConfig_r;
                default:       rdData_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstLocal)
    begin
        if (!rstLocal)
        begin
            hpConfig_r <= HP_CONFIG_RST;
            rdData_r   <= 8'h00;
            rdValid_r  <= 1'b0;
            stepCnt_r  <= 7'h00;
        end
        else
        begin
            hpConfig_r <= hpConfig_nxt;
            rdData_r   <= rdData_nxt;
            rdValid_r  <= regReq.rd;
            stepCnt_r  <= stepCnt_nxt;
        end
    end

    // Debounce timing: base tick near 1 MHz, then 2^(code-1) prescale
    logic [7:0]  mclkCnt_r;
    logic [7:0]  mclkCnt_nxt;
    logic [2:0]  oscCnt_r;
    logic [2:0]  oscCnt_nxt;
    logic [6:0]  preCnt_r;
    logic [6:0]  preCnt_nxt;
    logic [2:0]  debCnt_r;
    logic [2:0]  debCnt_nxt;
    logic        shortOut_r;
    logic        shortOut_nxt;
    debState_e   debState_r;
    debState_e   debState_nxt;
    logic [7:0]  mclkLimit;
    logic        mclkBase;
    logic        oscBase;
    logic        baseTick;
    logic        debTick;
    logic [2:0]  debCode;
    logic [6:0]  preLimit;

    always_comb
    begin
        debCode   = hpConfig_r[DEB_LSB+2 -: 3];
        // RL19 divisor zero means 128
        mclkLimit = (timerDivisor == 7'h00) ? MCLK_DIV_ZERO : {1'b0, timerDivisor};
        mclkBase  = mclkTick && (mclkCnt_r >= mclkLimit - 8'h01);
        mclkCnt_nxt = mclkCnt_r;
        if (mclkTick)
            mclkCnt_nxt = mclkBase ? 8'h00 : mclkCnt_r + 8'h01;
        // RL12 oscillator over eight
        oscBase    = oscTick && (oscCnt_r == 3'(OSC_DIV - 1));
        oscCnt_nxt = oscCnt_r;
        if (oscTick)
            oscCnt_nxt = oscCnt_r + 3'h1;
        baseTick = timerUseMclk ? mclkBase : oscBase;
        // RL11 period doubles per code
        preLimit = (debCode == 3'h0) ? 7'h00 : 7'((1 << (debCode - 3'h1)) - 1);
        debTick  = baseTick && (preCnt_r >= preLimit);
        preCnt_nxt = preCnt_r;
        if (baseTick)
            preCnt_nxt = debTick ? 7'h00 : preCnt_r + 7'h01;
        if (debState_r == DEB_IDLE)
            preCnt_nxt = 7'h00;
    end

    always_comb
    begin
        debState_nxt = debState_r;
        debCnt_nxt   = debCnt_r;
        shortOut_nxt = shortOut_r;
        unique case (debState_r)
            DEB_IDLE:
            begin
                shortOut_nxt = 1'b0;
                debCnt_nxt   = 3'h0;
                if (shortDetIn)
                begin
                    if (debCode == 3'h0)
                    begin
                        debState_nxt = DEB_SET;
                        shortOut_nxt = 1'b1;
                    end
                    else
                        debState_nxt = DEB_COUNT;
                end
            end
            DEB_COUNT:
            begin
                if (!shortDetIn)
                    debState_nxt = DEB_IDLE;
                // RL13 eight debounce periods
                else if (debTick)
                begin
                    debCnt_nxt = debCnt_r + 3'h1;
                    if (debCnt_r == 3'(DEB_PERIODS - 1))
                    begin
                        debState_nxt = DEB_SET;
                        shortOut_nxt = 1'b1;
                    end
                end
            end
            DEB_SET:
            begin
                if (!shortDetIn)
                begin
                    debState_nxt = DEB_IDLE;
                    shortOut_nxt = 1'b0;
                end
            end
            default:
            begin
                debState_nxt = DEB_IDLE;
                shortOut_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstLocal)
    begin
        if (!rstLocal)
        begin
            mclkCnt_r  <= 8'h00;
            oscCnt_r   <= 3'h0;
            preCnt_r   <= 7'h00;
            debCnt_r   <= 3'h0;
            shortOut_r <= 1'b0;
            debState_r <= DEB_IDLE;
        end
        else
        begin
            mclkCnt_r  <= mclkCnt_nxt;
            oscCnt_r   <= oscCnt_nxt;
            preCnt_r   <= preCnt_nxt;
            debCnt_r   <= debCnt_nxt;
            shortOut_r <= shortOut_nxt;
            debState_r <= debState_nxt;
        end
    end

    assign regRdData     = rdData_r;
    assign regRdValid    = rdValid_r;
    assign shortDetOut   = shortOut_r;
    assign leftHpGain    = drvCtrl_r[0][HP_GAIN_LSB+3-1 -: 4];
    assign leftHpUnmute  = drvCtrl_r[0][MUTE_BIT-1];
    assign rightHpGain   = drvCtrl_r[1][HP_GAIN_LSB+3-1 -: 4];
    assign rightHpUnmute = drvCtrl_r[1][MUTE_BIT-1];
    assign speakerGain   = drvCtrl_r[2][SPK_GAIN_LSB+1-1 -: 2];
    assign speakerUnmute = drvCtrl_r[2][MUTE_BIT-1];
    assign leftLineout   = hpConfig_r[LEFT_LINE_BIT];
    assign rightLineout  = hpConfig_r[RIGHT_LINE_BIT];
    assign dacPerfMode   = hpConfig_r[PERF_LSB+1 -: 2];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstLocal);

    sequence s_writeLeft;
        regReq.wr && regReq.addr == LEFT_HP_OFS;
    endsequence

    property p_leftGain;
        s_writeLeft |=> leftHpGain == $past(regReq.data[6:3]);
    endproperty
    a_leftGain: assert property (p_leftGain) else $error("left gain not stored"); // RL1

    property p_rightGain;
        regReq.wr && regReq.addr == RIGHT_HP_OFS |=> rightHpGain == $past(regReq.data[6:3]);
    endproperty
    a_rightGain: assert property (p_rightGain) else $error("right gain not stored"); // RL3

    property p_leftMute;
        s_writeLeft |=> leftHpUnmute == $past(regReq.data[2]);
    endproperty
    a_leftMute: assert property (p_leftMute) else $error("left mute not stored"); // RL4

    property p_rightMute;
        regReq.wr && regReq.addr == RIGHT_HP_OFS |=> rightHpUnmute == $past(regReq.data[2]);
    endproperty
    a_rightMute: assert property (p_rightMute) else $error("right mute not stored"); // RL5

    property p_spkGain;
        regReq.wr && regReq.addr == SPEAKER_OFS |=>
            speakerGain == $past(regReq.data[4:3]) && speakerUnmute == $past(regReq.data[2]);
    endproperty
    a_spkGain: assert property (p_spkGain) else $error("speaker field not stored"); // RL8

    property p_spkMute;
        regReq.wr && regReq.addr == SPEAKER_OFS && !regReq.data[2] |=> !speakerUnmute;
    endproperty
    a_spkMute: assert property (p_spkMute) else $error("speaker not muted"); // RL9

    property p_leftFlagRead;
        regReq.rd && regReq.addr == LEFT_HP_OFS |=> regRdValid && regRdData[0] == $past(settled[0]);
    endproperty
    a_leftFlagRead: assert property (p_leftFlagRead) else $error("left flag read wrong"); // RL6

    property p_rightFlagRead;
        regReq.rd && regReq.addr == RIGHT_HP_OFS |=> regRdData[0] == $past(settled[1]);
    endproperty
    a_rightFlagRead: assert property (p_rightFlagRead) else $error("right flag read wrong"); // RL7

    property p_spkSettle;
        regReq.wr && regReq.addr == SPEAKER_OFS && regReq.data[4:3] != speakerGain
            |=> !settled[2] ##[1:1000] settled[2];
    endproperty
    a_spkSettle: assert property (p_spkSettle) else $error("speaker flag not cycled"); // RL10

    property p_reservedZero;
        regReq.rd && regReq.addr == RESERVED_OFS |=> regRdData == 8'h00;
    endproperty
    a_reservedZero: assert property (p_reservedZero) else $error("reserved not zero"); // RL17

    property p_config;
        regReq.wr && regReq.addr == HP_CONFIG_OFS |=> dacPerfMode == $past(regReq.data[4:3])
            && leftLineout == $past(regReq.data[2]) && rightLineout == $past(regReq.data[1]);
    endproperty
    a_config: assert property (p_config) else $error("config not stored"); // RL14

    property p_debounceCount;
        debState_r == DEB_COUNT && shortOut_nxt |-> debTick && debCnt_r == 3'h7;
    endproperty
    a_debounceCount: assert property (p_debounceCount) else $error("debounce early"); // RL13

    property p_debouncePeriod;
        baseTick && debState_r == DEB_COUNT && debCode == 3'h2 && preCnt_r == 7'h00
            |-> !debTick;
    endproperty
    a_debouncePeriod: assert property (p_debouncePeriod) else $error("prescale wrong"); // RL11

endmodule

`default_nettype wire

//--- logic/output_driver_gain_control_pkg.sv
// Purpose: Constants and types for the output driver gain control block
// Assumes: 100 MHz core_clk, 7-bit register index within the selected page
// Notes:
// Overview of operation
// RL1: Left headphone gain code n gives n dB
// RL2: Software never writes headphone gain codes above nine
// RL3: Right headphone gain code n gives n dB
// RL4: Left headphone mute bit, 0 mutes, resets 0
// RL5: Right headphone mute bit, 0 mutes, resets 0
// RL6: Left gains-applied flag reads 1 when settled
// RL7: Right gains-applied flag reads 1 when settled
// RL8: Speaker gain two bits, 6 to 24 dB
// RL9: Speaker mute bit, 0 mutes, resets muted
// RL10: Speaker gains-applied flag reads 1 when settled
// RL11: Debounce code picks 0, 8 to 512 us
// RL12: Oscillator source scales debounce times proportionally
// RL13: Debounce spans eight periods of its clock
// RL14: Two-bit DAC performance mode field, 10 reserved
// RL15: Software writes 1 to right reserved bit
// RL16: Software writes zeros to other reserved bits
// RL17: Register after speaker reads zero, read-only
// RL18: Headphone or lineout select per headphone driver
// RL19: Timer clock is master clock over divisor
// RL20: Gain or mute change clears flag until settled

package output_driver_gain_control_pkg;

    localparam logic [6:0] LEFT_HP_OFS   = 7'h28;
    localparam logic [6:0] RIGHT_HP_OFS  = 7'h29;
    localparam logic [6:0] SPEAKER_OFS   = 7'h2A;
    localparam logic [6:0] RESERVED_OFS  = 7'h2B;
    localparam logic [6:0] HP_CONFIG_OFS = 7'h2C;

    // Stored bits 7..1 of each driver register
    localparam logic [6:0] LEFT_HP_RST   = 7'h01;
    localparam logic [6:0] RIGHT_HP_RST  = 7'h01;
    localparam logic [6:0] SPEAKER_RST   = 7'h00;
    localparam logic [7:0] HP_CONFIG_RST = 8'h00;
    localparam logic [7:0] RESERVED_VAL  = 8'h00;

    localparam int HP_GAIN_LSB  = 3;
    localparam int SPK_GAIN_LSB = 3;
    localparam int MUTE_BIT     = 2;
    localparam int DEB_LSB      = 5;
    localparam int PERF_LSB     = 3;
    localparam int LEFT_LINE_BIT  = 2;
    localparam int RIGHT_LINE_BIT = 1;

    // Gain ramp: one step per this time
    localparam int GAIN_STEP_NS   = 1000;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int GAIN_STEP_CYC  = (GAIN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_DIV        = 8;
    localparam logic [7:0] MCLK_DIV_ZERO = 8'h80;
    localparam int DEB_PERIODS    = 8;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] data;
    } regReq_s;

    typedef enum logic [1:0] {
        DEB_IDLE  = 2'b00,
        DEB_COUNT = 2'b01,
        DEB_SET   = 2'b10
    } debState_e;

endpackage

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the output driver gain control registers
// Assumes: Inputs change on the falling edge; reads answer one cycle after being taken
// Notes: Byte model of stored bits; the settle flag is polled under a bound
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import output_driver_gain_control_pkg::*;

    logic       core_clk      = 1'b0;
    logic       rstn          = 1'b0;
    regReq_s    regReq        = '0;
    logic [7:0] regRdData;
    logic       regRdValid;
    logic       timerUseMclk  = 1'b1;
    logic [6:0] timerDivisor  = 7'h02;
    logic       mclkTick      = 1'b0;
    logic       oscTick       = 1'b0;
    logic       shortDetIn    = 1'b0;
    logic       shortDetOut;
    logic [3:0] leftHpGain;
    logic       leftHpUnmute;
    logic [3:0] rightHpGain;
    logic       rightHpUnmute;
    logic [1:0] speakerGain;
    logic       speakerUnmute;
    logic       leftLineout;
    logic       rightLineout;
    logic [1:0] dacPerfMode;
    logic [7:0] tickCnt       = 8'h00;
    logic [7:0] stored [0:4];
    int         seed          = 45935;
    int         errCount      = 0;
    int         totalChecks   = 0;

    output_driver_gain_control dut
    (
        .core_clk      (core_clk),
        .rstn          (rstn),
        .regReq        (regReq),
        .regRdData     (regRdData),
        .regRdValid    (regRdValid),
        .timerUseMclk  (timerUseMclk),
        .timerDivisor  (timerDivisor),
        .mclkTick      (mclkTick),
        .oscTick       (oscTick),
        .shortDetIn    (shortDetIn),
        .shortDetOut   (shortDetOut),
        .leftHpGain    (leftHpGain),
        .leftHpUnmute  (leftHpUnmute),
        .rightHpGain   (rightHpGain),
        .rightHpUnmute (rightHpUnmute),
        .speakerGain   (speakerGain),
        .speakerUnmute (speakerUnmute),
        .leftLineout   (leftLineout),
        .rightLineout  (rightLineout),
        .dacPerfMode   (dacPerfMode)
    );

    always #5 core_clk = ~core_clk;

    // Master clock ticks every 2 cycles, oscillator ticks in the other phase
    always @(negedge core_clk)
    begin
        tickCnt  <= tickCnt + 8'h01;
        mclkTick <= tickCnt[0];
        oscTick  <= ~tickCnt[0];
    end

    task automatic endOfTest();
        $display("checks %0d, mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic checkByte(input string name, input logic [7:0] e, input logic [7:0] g);
        totalChecks++;
        if (g !== e)
        begin
            errCount++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic checkBit(input string name, input logic e, input logic g);
        totalChecks++;
        if (g !== e)
        begin
            errCount++;
            $display("wrong value %s expected %b seen %b", name, e, g);
        end
    endtask

    task automatic regWrite(input logic [6:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regReq = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(negedge core_clk);
        regReq = '0;
    endtask

    task automatic regRead(input logic [6:0] a, output logic [7:0] d);
        @(negedge core_clk);
        regReq = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        // Answer stands only for the cycle after the taking edge
        @(negedge core_clk);
        checkBit("regRdValid", 1'b1, regRdValid);
        d = regRdData;
        regReq = '0;
    endtask

    task automatic doReset();
        @(negedge core_clk);
        rstn = 1'b0;
        repeat (5) @(negedge core_clk);
        rstn = 1'b1;
        // Two sync flops, first request on the third edge
        repeat (3) @(negedge core_clk);
        stored = '{8'h02, 8'h02, 8'h00, 8'h00, 8'h00};
    endtask

    // Poll until the settle flag reads 1, bounded by the longest ramp
    task automatic waitFlag(input int idx);
        logic [7:0] d;
        int         n;
        n = 0;
        d = 8'h00;
        while (d[0] !== 1'b1 && n < 80)
        begin
            repeat (15) @(negedge core_clk);
            regRead(LEFT_HP_OFS + idx[6:0], d);
            n++;
        end
        if (d[0] !== 1'b1)
        begin
            errCount++;
            $display("wrong value settle flag wait ran out");
            endOfTest();
        end
        checkByte("settled read", {stored[idx][7:1], 1'b1}, d);
    endtask

    task automatic debounceRun(input logic src, input logic [2:0] code, input int base);
        int   per;
        int   n;
        logic hit;
        per = (code == 3'h0) ? 1 : base << (code - 3'h1);
        stored[4][7:5] = code;
        regWrite(HP_CONFIG_OFS, stored[4]);
        timerUseMclk = src;
        repeat (2) @(negedge core_clk);
        shortDetIn = 1'b1;
        hit = 1'b0;
        n = 0;
        while (hit == 1'b0 && n < 9 * per + 8)
        begin
            @(negedge core_clk);
            n++;
            if (shortDetOut === 1'b1)
                hit = 1'b1;
        end
        checkBit("shortDetOut rise", 1'b1, hit);
        checkBit("shortDetOut not early", 1'b1, n >= ((code == 3'h0) ? 1 : 7 * per));
        shortDetIn = 1'b0;
        repeat (2) @(negedge core_clk);
        checkBit("shortDetOut drop", 1'b0, shortDetOut);
    endtask

    initial
    begin
        logic [7:0] d;
        logic [7:0] w;
        logic [3:0] g;
        logic [3:0] og;
        int         idx;
        doReset();
        for (int a = 0; a < 5; a++)
        begin
            regRead(LEFT_HP_OFS + a[6:0], d);
            checkByte("reset read", stored[a] | {7'h00, a < 3}, d);
        end
        repeat (8)
        begin
            idx = $unsigned($random(seed)) % 3;
            g   = (idx == 2) ? 4'($unsigned($random(seed)) % 4) : 4'($unsigned($random(seed)) % 10);
            og  = (idx == 2) ? {2'b00, stored[2][4:3]} : stored[idx][6:3];
            // Reserved bits written as required, bit 0 random
            if (idx == 2)
                w = {3'b000, g[1:0], 1'($random(seed)), 1'b0, 1'($random(seed))};
            else
                w = {1'b0, g, 1'($random(seed)), 1'b1, 1'($random(seed))};
            regWrite(LEFT_HP_OFS + idx[6:0], w);
            stored[idx] = w & 8'hFE;
            @(negedge core_clk);
            if (idx == 0)
            begin
                checkByte("leftHpGain", {4'h0, w[6:3]}, {4'h0, leftHpGain});
                checkBit("leftHpUnmute", w[2], leftHpUnmute);
            end
            else if (idx == 1)
            begin
                checkByte("rightHpGain", {4'h0, w[6:3]}, {4'h0, rightHpGain});
                checkBit("rightHpUnmute", w[2], rightHpUnmute);
            end
            else
            begin
                checkByte("speakerGain", {6'h00, w[4:3]}, {6'h00, speakerGain});
                checkBit("speakerUnmute", w[2], speakerUnmute);
            end
            // A ramp of two or more codes cannot be done yet
            if (g > og + 4'h1 || og > g + 4'h1)
            begin
                regRead(LEFT_HP_OFS + idx[6:0], d);
                checkByte("pending read", stored[idx], d);
            end
            waitFlag(idx);
        end
        regWrite(RESERVED_OFS, 8'($random(seed)));
        regRead(RESERVED_OFS, d);
        checkByte("reserved read", RESERVED_VAL, d);
        regRead(7'h30, d);
        checkByte("unmapped read", 8'h00, d);
        for (int i = 0; i < 3; i++)
        begin
            regRead(LEFT_HP_OFS + 7'(i), d);
            checkByte("driver unchanged", stored[i] | 8'h01, d);
        end
        for (int p = 0; p < 4; p++)
        begin
            if (p == 2)
                continue;
            w = {3'b000, 2'(p), 1'($random(seed)), 1'($random(seed)), 1'b0};
            regWrite(HP_CONFIG_OFS, w);
            stored[4] = w;
            @(negedge core_clk);
            checkByte("dacPerfMode", {6'h00, w[4:3]}, {6'h00, dacPerfMode});
            checkBit("leftLineout", w[2], leftLineout);
            checkBit("rightLineout", w[1], rightLineout);
            regRead(HP_CONFIG_OFS, d);
            checkByte("config read", w, d);
        end
        debounceRun(1'b1, 3'h0, 4);
        debounceRun(1'b1, 3'h1, 4);
        debounceRun(1'b1, 3'h3, 4);
        debounceRun(1'b0, 3'h2, 16);
        doReset();
        regRead(LEFT_HP_OFS, d);
        checkByte("read after second reset", 8'h03, d);
        checkBit("speakerUnmute after reset", 1'b0, speakerUnmute);
        endOfTest();
    end

    initial
    begin
        #1000000;
        errCount++;
        $display("wrong value run time limit reached");
        endOfTest();
    end
endmodule

`default_nettype wire
